// file: hw/ctp_timer.sv
// Purpose: compact 10-bit timer with compare, timer and PWM modes
// Assumes: Avalon-MM register access, one core clock, counter ticks as enables
// Notes: flags are sticky and cleared by writing one to the flag register
`timescale 1ns/1ps
`default_nettype none
module ctp_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic high_clk_tick,
  input wire logic sub_clk_tick,
  input wire logic ext_clk_pin,
  output logic timer_out,
  output logic timer_out_oe,
  output logic match_a_flag,
  output logic match_p_flag
);
  ctp_pkg::ctp_ctrl0_s ctrl0;
  ctp_pkg::ctp_ctrl1_s ctrl1;
  logic [9:0] compare_a_value;
  logic [9:0] count;
  logic enable_last;
  logic pin_level;
  logic count_tick;
  logic acc_fire;
  logic acc_write;
  logic acc_valid;
  logic [3:0] acc_index;
  logic wr;
  logic enable_rise;
  logic a_hit;
  logic p_hit;
  logic at_max;
  logic clear_now;
  logic a_event;
  logic p_event;
  logic [10:0] pwm_period;
  logic [10:0] pwm_duty;
  logic pwm_active;
  logic pwm_level;
  logic pwm_mode;
  logic [7:0] next_readdata;

  // size a P field into clocks, zero standing for the full range
  function automatic logic [10:0] p_span(input logic [2:0] p);
    p_span = (p == 3'h0) ? 11'h400 : {1'b0, p, 7'h00};
  endfunction

  ctp_tick_gen u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .clock_select(ctrl0.clock_select),
    .high_clk_tick(high_clk_tick),
    .sub_clk_tick(sub_clk_tick),
    .ext_clk_pin(ext_clk_pin),
    .count_tick(count_tick)
  );

  ctp_avalon_slave u_bus (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest),
    .acc_fire(acc_fire),
    .acc_write(acc_write),
    .acc_valid(acc_valid),
    .acc_index(acc_index)
  );

  assign wr = acc_fire && acc_write && acc_valid;
  assign enable_rise = ctrl0.timer_enable && !enable_last;
  assign pwm_mode = (ctrl1.mode == ctp_pkg::CTP_MODE_PWM);

  // comparators, evaluated on a counter tick
  assign a_hit = (count == compare_a_value) && (compare_a_value != 10'h000);
  assign p_hit = (count[9:7] == ctrl0.period_p_value) &&
                 (ctrl0.period_p_value != 3'h0) && (count[6:0] == 7'h00)
                 && (count != 10'h000);
  assign at_max = (count == ctp_pkg::COUNT_MAX);

  // match events and the clear decision per mode
  always_comb begin
    a_event = 1'b0;
    p_event = 1'b0;
    clear_now = 1'b0;
    if (pwm_mode) begin
      a_event = a_hit;
      p_event = p_hit || (at_max && ctrl0.period_p_value == 3'h0);
      if (ctrl1.duty_period_swap) begin
        clear_now = a_hit || at_max;
      end else begin
        clear_now = p_event;
      end
    end else if (ctrl1.clear_source_select) begin
      a_event = a_hit;
      clear_now = a_hit || at_max;
    end else begin
      a_event = a_hit;
      p_event = p_hit || (at_max && ctrl0.period_p_value == 3'h0);
      clear_now = p_event;
    end
  end

  // counter: zero on enable rise, hold when off or paused
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 10'h000;
      enable_last <= 1'b0;
    end else if (clk_en) begin
      enable_last <= ctrl0.timer_enable;
      if (enable_rise) begin
        count <= 10'h000;
      end else if (ctrl0.timer_enable && !ctrl0.counter_pause && count_tick) begin
        if (clear_now) begin
          count <= 10'h000;
        end else begin
          count <= count + 10'h001;
        end
      end
    end
  end

  // flag events only count while the counter is advancing
  logic tick_live;
  assign tick_live = ctrl0.timer_enable && !ctrl0.counter_pause
                     && count_tick && !enable_rise;

  // sticky flags: a new event wins over a software clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else if (clk_en) begin
      if (tick_live && a_event) begin
        match_a_flag <= 1'b1;
      end else if (wr && acc_index == ctp_pkg::ADDR_FLAGS && avs_writedata[0]) begin
        match_a_flag <= 1'b0;
      end
      if (tick_live && p_event) begin
        match_p_flag <= 1'b1;
      end else if (wr && acc_index == ctp_pkg::ADDR_FLAGS && avs_writedata[1]) begin
        match_p_flag <= 1'b0;
      end
    end
  end

  // control and compare registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0 <= ctp_pkg::REG_RESET;
      ctrl1 <= ctp_pkg::REG_RESET;
      compare_a_value <= 10'h000;
    end else if (clk_en && wr) begin
      case (acc_index)
        ctp_pkg::ADDR_CONTROL_ZERO: ctrl0 <= avs_writedata[7:0];
        ctp_pkg::ADDR_CONTROL_ONE: ctrl1 <= avs_writedata[7:0];
        ctp_pkg::ADDR_CMPA_LOW: compare_a_value[7:0] <= avs_writedata[7:0];
        ctp_pkg::ADDR_CMPA_HIGH: compare_a_value[9:8] <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  // PWM period and duty selection
  always_comb begin
    if (ctrl1.duty_period_swap) begin
      pwm_period = {1'b0, compare_a_value};
      pwm_duty = p_span(ctrl0.period_p_value);
    end else begin
      pwm_period = p_span(ctrl0.period_p_value);
      pwm_duty = {1'b0, compare_a_value};
    end
  end
  assign pwm_active = (pwm_duty >= pwm_period) ||
                      ({1'b0, count} < pwm_duty);

  // PWM level from the pin function code, before polarity and inversion
  always_comb begin
    case (ctrl1.pin_function)
      ctp_pkg::PF_NONE: pwm_level = 1'b0;
      ctp_pkg::PF_LOW: pwm_level = 1'b1;
      ctp_pkg::PF_HIGH: pwm_level = pwm_active;
      default: pwm_level = 1'b0;
    endcase
  end

  // compare-mode pin state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level <= 1'b0;
    end else if (clk_en) begin
      if (enable_rise) begin
        pin_level <= ctrl1.output_initial_level;
      end else if (ctrl1.mode == ctp_pkg::CTP_MODE_COMPARE
                   && tick_live && a_event) begin
        case (ctrl1.pin_function)
          ctp_pkg::PF_LOW: pin_level <= 1'b0;
          ctp_pkg::PF_HIGH: pin_level <= 1'b1;
          ctp_pkg::PF_TOGGLE: pin_level <= !pin_level;
          default: pin_level <= pin_level;
        endcase
      end
    end
  end

  // registered pin drive
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_out <= 1'b0;
      timer_out_oe <= 1'b0;
    end else if (clk_en) begin
      timer_out_oe <= (ctrl1.mode == ctp_pkg::CTP_MODE_COMPARE) || pwm_mode;
      if (pwm_mode) begin
        timer_out <= (pwm_level ~^ ctrl1.output_initial_level)
                     ^ ctrl1.output_invert;
      end else begin
        timer_out <= pin_level ^ ctrl1.output_invert;
      end
    end
  end

  // read mux
  always_comb begin
    case (acc_index)
      ctp_pkg::ADDR_CONTROL_ZERO: next_readdata = ctrl0;
      ctp_pkg::ADDR_CONTROL_ONE: next_readdata = ctrl1;
      ctp_pkg::ADDR_COUNT_LOW: next_readdata = count[7:0];
      ctp_pkg::ADDR_COUNT_HIGH: next_readdata = {6'h00, count[9:8]};
      ctp_pkg::ADDR_CMPA_LOW: next_readdata = compare_a_value[7:0];
      ctp_pkg::ADDR_CMPA_HIGH: next_readdata = {6'h00, compare_a_value[9:8]};
      ctp_pkg::ADDR_FLAGS: next_readdata = {6'h00, match_p_flag, match_a_flag};
      default: next_readdata = 8'h00;
    endcase
    if (!acc_valid) begin
      next_readdata = 8'h00;
    end
  end

  // read data registered as the access completes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en && avs_waitrequest && avs_read) begin
      avs_readdata <= {24'h000000, next_readdata};
    end
  end

  chk_clear_restart: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && tick_live && clear_now |=> count == 10'h000)
    else $error("counter not cleared after match");
  chk_enable_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && enable_rise |=> count == 10'h000)
    else $error("counter not zeroed on enable rise");
  chk_no_p_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && !pwm_mode && ctrl1.clear_source_select && !match_p_flag
    |=> !match_p_flag || $past(wr))
    else $error("P flag raised with A clear");
  chk_a_flag_set: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && tick_live && a_event |=> match_a_flag)
    else $error("A flag missed");
  chk_pause_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && ctrl0.counter_pause && !enable_rise |=> $stable(count))
    else $error("counter moved while paused");
  chk_init_level: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && enable_rise |=> pin_level == $past(ctrl1.output_initial_level))
    else $error("pin not at initial level");
  chk_timer_nodrive: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && ctrl1.mode == ctp_pkg::CTP_MODE_TIMER |=> !timer_out_oe)
    else $error("pin driven in timer mode");
  chk_high_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    acc_index == ctp_pkg::ADDR_COUNT_HIGH |-> next_readdata[7:2] == 6'h00)
    else $error("high byte upper bits not zero");
  chk_p_flag_set: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && tick_live && p_event |=> match_p_flag)
    else $error("P flag missed");
  // a software clear that no new event collides with
  sequence s_a_clear_only;
    clk_en && wr && acc_index == ctp_pkg::ADDR_FLAGS && avs_writedata[0]
    && !(tick_live && a_event);
  endsequence
  chk_a_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_a_clear_only |=> !match_a_flag)
    else $error("A flag not cleared by software");
  chk_a_sticky: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    match_a_flag && !(wr && acc_index == ctp_pkg::ADDR_FLAGS)
    |=> match_a_flag)
    else $error("A flag dropped without a clear");
  // an A match that the compare-mode pin logic acts on
  sequence s_compare_a_match;
    clk_en && ctrl1.mode == ctp_pkg::CTP_MODE_COMPARE
    && tick_live && a_event;
  endsequence
  chk_pin_high: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_compare_a_match ##0 ctrl1.pin_function == ctp_pkg::PF_HIGH
    |=> pin_level)
    else $error("pin not driven high on A match");
  chk_pin_toggle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_compare_a_match ##0 ctrl1.pin_function == ctp_pkg::PF_TOGGLE
    |=> pin_level != $past(pin_level))
    else $error("pin not toggled on A match");
  chk_pin_only_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && ctrl1.mode == ctp_pkg::CTP_MODE_COMPARE && !enable_rise
    && !(tick_live && a_event) |=> $stable(pin_level))
    else $error("pin moved without an A match");
  chk_pwm_forced: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && pwm_mode && ctrl1.pin_function == ctp_pkg::PF_NONE
    |=> timer_out == ($past(ctrl1.output_initial_level)
                      ~^ $past(ctrl1.output_invert)))
    else $error("pwm pin not forced inactive");
endmodule
`default_nettype wire

// file: hw/ctp_pkg.sv
// Purpose: shared constants and types for the compact timer
// Assumes: registers are 8 bits wide, one per aligned 32-bit word
// Notes: byte addresses are multiples of four
package ctp_pkg;
  localparam logic [3:0] ADDR_CONTROL_ZERO = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_ONE = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_CMPA_LOW = 4'h4;
  localparam logic [3:0] ADDR_CMPA_HIGH = 4'h5;
  localparam logic [3:0] ADDR_FLAGS = 4'h6;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [9:0] COUNT_MAX = 10'h3ff;
  localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CKS_SYS = 3'h1;
  localparam logic [2:0] CKS_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CKS_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CKS_SUB_A = 3'h4;
  localparam logic [2:0] CKS_SUB_B = 3'h5;
  localparam logic [2:0] CKS_PIN_RISE = 3'h6;
  localparam logic [2:0] CKS_PIN_FALL = 3'h7;
  localparam logic [5:0] DIV_SYS4 = 6'h03;
  localparam logic [5:0] DIV_HIGH16 = 6'h0f;
  localparam logic [5:0] DIV_HIGH64 = 6'h3f;
  localparam logic [1:0] PF_NONE = 2'h0;
  localparam logic [1:0] PF_LOW = 2'h1;
  localparam logic [1:0] PF_HIGH = 2'h2;
  localparam logic [1:0] PF_TOGGLE = 2'h3;
  typedef enum logic [1:0] {
    CTP_MODE_COMPARE = 2'b00,
    CTP_MODE_UNDEF = 2'b01,
    CTP_MODE_PWM = 2'b10,
    CTP_MODE_TIMER = 2'b11
  } ctp_mode_e;
  typedef struct packed {
    logic counter_pause;
    logic [2:0] clock_select;
    logic timer_enable;
    logic [2:0] period_p_value;
  } ctp_ctrl0_s;
  typedef struct packed {
    ctp_mode_e mode;
    logic [1:0] pin_function;
    logic output_initial_level;
    logic output_invert;
    logic duty_period_swap;
    logic clear_source_select;
  } ctp_ctrl1_s;
endpackage

// file: hw/ctp_tick_gen.sv
// Purpose: counter clock enable generation for the compact timer
// Assumes: high and sub clocks arrive as enables on core_clk
// Notes: external pin is synchronised here by two flip-flops
`timescale 1ns/1ps
`default_nettype none
module ctp_tick_gen (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [2:0] clock_select,
  input wire logic high_clk_tick,
  input wire logic sub_clk_tick,
  input wire logic ext_clk_pin,
  output logic count_tick
);
  logic [5:0] sys_div;
  logic [5:0] high_div;
  logic [1:0] pin_sync;
  logic pin_last;
  // free-running prescalers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_div <= 6'h00;
      high_div <= 6'h00;
    end else if (clk_en) begin
      sys_div <= sys_div + 6'h01;
      if (high_clk_tick) begin
        high_div <= high_div + 6'h01;
      end
    end
  end
  // two-stage synchroniser then edge memory
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync <= 2'b00;
      pin_last <= 1'b0;
    end else if (clk_en) begin
      pin_sync <= {pin_sync[0], ext_clk_pin};
      pin_last <= pin_sync[1];
    end
  end
  // source selection
  always_comb begin
    case (clock_select)
      ctp_pkg::CKS_SYS_DIV4: count_tick = (sys_div[1:0] == ctp_pkg::DIV_SYS4[1:0]);
      ctp_pkg::CKS_SYS: count_tick = 1'b1;
      ctp_pkg::CKS_HIGH_DIV16:
        count_tick = high_clk_tick && (high_div[3:0] == ctp_pkg::DIV_HIGH16[3:0]);
      ctp_pkg::CKS_HIGH_DIV64:
        count_tick = high_clk_tick && (high_div == ctp_pkg::DIV_HIGH64);
      ctp_pkg::CKS_SUB_A: count_tick = sub_clk_tick;
      ctp_pkg::CKS_SUB_B: count_tick = sub_clk_tick;
      ctp_pkg::CKS_PIN_RISE: count_tick = pin_sync[1] && !pin_last;
      ctp_pkg::CKS_PIN_FALL: count_tick = !pin_sync[1] && pin_last;
      default: count_tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: hw/ctp_avalon_slave.sv
// Purpose: Avalon-MM slave front end for the compact timer registers
// Assumes: one-cycle waitrequest on every access
// Notes: unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/1ps
`default_nettype none
module ctp_avalon_slave (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  output logic avs_waitrequest,
  output logic acc_fire,
  output logic acc_write,
  output logic acc_valid,
  output logic [3:0] acc_index
);
  logic done;
  // waitrequest drops for one cycle after a request is seen
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (clk_en) begin
      done <= (avs_read || avs_write) && !done;
    end
  end
  assign avs_waitrequest = !done;
  assign acc_fire = done && clk_en && (avs_read || avs_write);
  assign acc_write = avs_write && avs_byteenable[0];
  assign acc_index = avs_address[5:2];
  assign acc_valid = (avs_address[1:0] == 2'b00) &&
                     (avs_address[5:2] <= ctp_pkg::ADDR_FLAGS);
endmodule
`default_nettype wire

// file: test/ctp_timer_tb.sv
// Purpose: self-checking bench for the compact timer
// Assumes: counter ticks every core clock (clock select 001), except in the CKS_SYS_DIV4 and CKS_PIN_RISE cases
// Notes: register and pwm cases are table driven, the rest by hand
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_tb;
  typedef struct {logic wr; logic [3:0] idx; logic [7:0] wd; logic [7:0] ex;}
    ctp_reg_row_s;
  typedef struct {logic sw; logic [7:0] a; logic [1:0] pf; logic ini;
    logic inv; logic clr; int hi;} ctp_pwm_row_s;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, timer_out, timer_out_oe, match_a_flag, match_p_flag;
  int fail_count = 0;
  int compares = 0;
  int n, hi;
  logic ini;
  logic [7:0] q1, q2;
  logic ext_pin = 1'b0;
  // register rows: write, word index, write data, expected read
  ctp_reg_row_s regs[20] = '{
    '{0, 4'h0, 8'h00, 8'h00}, '{0, 4'h1, 8'h00, 8'h00},
    '{0, 4'h2, 8'h00, 8'h00}, '{0, 4'h3, 8'h00, 8'h00},
    '{0, 4'h4, 8'h00, 8'h00}, '{0, 4'h5, 8'h00, 8'h00},
    '{0, 4'h6, 8'h00, 8'h00}, '{0, 4'h7, 8'h00, 8'h00},
    '{1, 4'h4, 8'ha5, 8'h00}, '{0, 4'h4, 8'h00, 8'ha5},
    '{1, 4'h5, 8'hff, 8'h00}, '{0, 4'h5, 8'h00, 8'h03},
    '{1, 4'h3, 8'hff, 8'h00}, '{0, 4'h3, 8'h00, 8'h00},
    '{1, 4'h7, 8'h55, 8'h00}, '{0, 4'h7, 8'h00, 8'h00},
    '{1, 4'h1, 8'hff, 8'h00}, '{0, 4'h1, 8'h00, 8'hff},
    '{1, 4'h1, 8'h00, 8'h00}, '{1, 4'h5, 8'h00, 8'h00}};
  // pwm rows: swap, compare a, pin code, level, invert, clear, high of 256
  ctp_pwm_row_s pwm[8] = '{
    '{0, 8'd32, 2'h2, 1, 0, 0, 64}, '{0, 8'd32, 2'h2, 1, 1, 0, 192},
    '{0, 8'd32, 2'h2, 0, 0, 0, 192}, '{0, 8'd32, 2'h2, 1, 0, 1, 64},
    '{0, 8'd200, 2'h2, 1, 0, 0, 256}, '{0, 8'd32, 2'h0, 1, 0, 0, 0},
    '{0, 8'd32, 2'h1, 1, 0, 0, 256}, '{1, 8'd255, 2'h2, 1, 0, 0, 128}};

  ctp_timer u_ctp_timer (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .high_clk_tick(1'b0), .sub_clk_tick(1'b0), .ext_clk_pin(ext_pin),
    .timer_out(timer_out), .timer_out_oe(timer_out_oe),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

  // free-running core clock, 20 ns period
  always #10 core_clk = ~core_clk;

  task automatic tally_and_finish;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] ex);
    compares++;
    if (got !== ex) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask

  // count compare with a tolerance for edge alignment
  task automatic near(input int got, input int ex, input int tol);
    chk(16'((got >= ex - tol && got <= ex + tol) ? ex : got), 16'(ex));
  endtask

  // one avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    if (k >= 100) fail_count++;
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] ex);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk({8'h00, q}, {8'h00, ex});
  endtask

  function automatic logic [7:0] c1(input ctp_pkg::ctp_mode_e m,
    input logic [1:0] pf, input logic lv, input logic inv, input logic sw,
    input logic clr);
    return {m, pf, lv, inv, sw, clr};
  endfunction

  // stop, clear flags, load compare a and control one, then enable
  task automatic setup(input logic [9:0] a, input logic [7:0] ctl1,
                       input logic [2:0] p);
    wr(ctp_pkg::ADDR_CONTROL_ZERO, 8'h00);
    wr(ctp_pkg::ADDR_FLAGS, 8'h03);
    wr(ctp_pkg::ADDR_CMPA_LOW, a[7:0]);
    wr(ctp_pkg::ADDR_CMPA_HIGH, {6'h00, a[9:8]});
    wr(ctp_pkg::ADDR_CONTROL_ONE, ctl1);
    wr(ctp_pkg::ADDR_CONTROL_ZERO, {1'b0, ctp_pkg::CKS_SYS, 1'b1, p});
  endtask

  task automatic wait_flag(input logic p, output int k);
    k = 0;
    while ((p ? match_p_flag : match_a_flag) !== 1'b1 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
  endtask

  task automatic count_high(input int len, output int h);
    h = 0;
    repeat (len) begin
      @(negedge core_clk);
      if (timer_out === 1'b1) h++;
    end
  endtask

  // watchdog sized well above the expected run of about 5700 cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    $display("watchdog expired at t=%0t", $time);
    tally_and_finish;
  end

  initial begin
    repeat (5) @(negedge core_clk);
    chk(16'({timer_out, timer_out_oe, match_a_flag, match_p_flag,
             avs_waitrequest}), 16'h0001);
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    // register reset values, access kinds and an unmapped word
    foreach (regs[i]) begin
      if (regs[i].wr) wr(regs[i].idx, regs[i].wd);
      else rd_chk(regs[i].idx, regs[i].ex);
    end
    $display("test register rows done");
    // pwm waveform rows over 256 clocks, two periods of 128 except one period of 256 in the swap row
    foreach (pwm[i]) begin
      setup(10'(pwm[i].a), c1(ctp_pkg::CTP_MODE_PWM, pwm[i].pf, pwm[i].ini,
            pwm[i].inv, pwm[i].sw, pwm[i].clr), 3'h1);
      repeat (20) @(negedge core_clk);
      count_high(256, hi);
      near(hi, pwm[i].hi, 4);
      chk(16'(timer_out_oe), 16'h0001);
      if (i == 0) chk(16'({match_a_flag, match_p_flag}), 16'h0003);
      $display("test pwm row %0d done", i);
    end
    // compare mode, clear on a match, every pin function code
    for (int f = 0; f < 4; f++) begin
      ini = (f == 2) ? 1'b0 : 1'b1;
      setup(10'd40, c1(ctp_pkg::CTP_MODE_COMPARE, 2'(f), ini, 1'b0, 1'b0,
            1'b1), 3'h1);
      repeat (3) @(negedge core_clk);
      chk(16'(timer_out), 16'(ini));
      wait_flag(1'b0, n);
      @(negedge core_clk);
      chk(16'(timer_out), 16'(f == 0 || f == 2));
      repeat (200) @(negedge core_clk);
      chk(16'(match_p_flag), 16'h0000);
      $display("test compare pin code %0d done", f);
    end
    wr(ctp_pkg::ADDR_CONTROL_ZERO, 8'h00);
    rd_chk(ctp_pkg::ADDR_FLAGS, 8'h01);
    wr(ctp_pkg::ADDR_FLAGS, 8'h03);
    rd_chk(ctp_pkg::ADDR_FLAGS, 8'h00);
    // period p clears the counter in compare and timer modes
    for (int m = 0; m < 2; m++) begin
      setup(10'd300, c1(m ? ctp_pkg::CTP_MODE_TIMER : ctp_pkg::CTP_MODE_COMPARE,
            ctp_pkg::PF_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b0), 3'h1);
      wait_flag(1'b1, n);
      near(n, 128, 6);
      chk(16'(timer_out_oe), 16'(m == 0));
      if (m == 0) chk(16'(timer_out), 16'h0001);
      rd_chk(ctp_pkg::ADDR_COUNT_HIGH, 8'h00);
    end
    wr(ctp_pkg::ADDR_CONTROL_ZERO, 8'h00);
    wr(ctp_pkg::ADDR_FLAGS, 8'h03);
    wr(ctp_pkg::ADDR_CONTROL_ZERO, {1'b0, ctp_pkg::CKS_SYS_DIV4, 1'b1, 3'h1});
    wait_flag(1'b1, n);
    near(n, 512, 12);
    $display("test period match done");
    // clear on a with a zero: runs to overflow, no a flag
    setup(10'd0, c1(ctp_pkg::CTP_MODE_COMPARE, ctp_pkg::PF_TOGGLE, 1'b1,
          1'b0, 1'b0, 1'b1), 3'h0);
    repeat (600) @(negedge core_clk);
    rd_chk(ctp_pkg::ADDR_COUNT_HIGH, 8'h02);
    repeat (600) @(negedge core_clk);
    rd_chk(ctp_pkg::ADDR_COUNT_HIGH, 8'h00);
    chk(16'({match_a_flag, timer_out}), 16'h0001);
    // pause holds the count, enable rise zeroes it
    wr(ctp_pkg::ADDR_CONTROL_ZERO, {1'b1, ctp_pkg::CKS_SYS, 1'b1, 3'h0});
    bus(1'b0, ctp_pkg::ADDR_COUNT_LOW, 8'h00, q1);
    repeat (50) @(negedge core_clk);
    bus(1'b0, ctp_pkg::ADDR_COUNT_LOW, 8'h00, q2);
    chk(16'(q2), 16'(q1));
    wr(ctp_pkg::ADDR_CONTROL_ZERO, 8'h00);
    wr(ctp_pkg::ADDR_CONTROL_ZERO, {1'b0, ctp_pkg::CKS_SYS, 1'b1, 3'h0});
    bus(1'b0, ctp_pkg::ADDR_COUNT_LOW, 8'h00, q2);
    near(int'(q2), 3, 3);
    $display("test overflow and pause done");
    // external pin clock: ten rising edges give ten counts
    wr(ctp_pkg::ADDR_CONTROL_ZERO, 8'h00);
    wr(ctp_pkg::ADDR_CONTROL_ZERO, {1'b0, ctp_pkg::CKS_PIN_RISE, 1'b1, 3'h0});
    repeat (20) begin
      repeat (3) @(posedge core_clk);
      ext_pin <= ~ext_pin;
    end
    repeat (4) @(posedge core_clk);
    rd_chk(ctp_pkg::ADDR_COUNT_LOW, 8'h0a);
    $display("test pin clock done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
